// ---- otfs_pkg.sv ----
// package of constants for the output terminal function selector
// Operation
// - code 1: ready, voltage normal, no stop
// - codes 4,5,6: fault, alarm, either
// - code 8: run command input present
// - code 9 zero speed while running, 10 nonzero
// - code 13 accelerating, 14 decelerating
// - codes 16,17: fieldbus or module writes terminal
// - code 19: 0.5s pulse per stage done
// - code 20 pulse, 21 level on completion
// - code 22: 0.5s pulse per cycle done
// - code 24 A leads, 25 A lags
// - code 26: below lower, hold until above upper
// - code 27: above upper, hold until below lower
// - code 28: first variable inside window
// - codes 29-31: same for second variable
// - codes 32-34: same for third variable
// - comparisons use magnitude only
// - code 35: positioning reached target
// - codes 36-38: analog input wire break
// - codes 40-49: counter and timer outputs
// - codes 55-62 mirror digital inputs one-eight
// - code 63 frequency output, third terminal only
`default_nettype none
package otfs_pkg;
  // apb register map
  localparam logic [11:0] OTFS_SEL_OFS  = 12'h000; // code word per terminal
  localparam logic [11:0] OTFS_BUS_OFS  = 12'h004; // fieldbus written bits
  localparam logic [11:0] OTFS_MOD_OFS  = 12'h008; // module written bits
  localparam logic [11:0] OTFS_STAT_OFS = 12'h00c; // terminal states
  localparam logic [11:0] OTFS_STR_OFS  = 12'h010; // hysteresis flag states
  localparam int          OTFS_CODE_W   = 7;       // field width per code
  localparam int          OTFS_CODE_STRIDE = 8;    // field spacing in word
  localparam logic [6:0]  OTFS_CODE_RST = 7'h00;   // reset code: none
  // function codes
  localparam logic [6:0] C_READY = 7'h01, C_FAULT = 7'h04, C_ALARM = 7'h05;
  localparam logic [6:0] C_FLTALM = 7'h06, C_RUNCMD = 7'h08;
  localparam logic [6:0] C_ZERO = 7'h09, C_NZERO = 7'h0a;
  localparam logic [6:0] C_ACC = 7'h0d, C_DEC = 7'h0e;
  localparam logic [6:0] C_BUS = 7'h10, C_MOD = 7'h11;
  localparam logic [6:0] C_STAGE = 7'h13, C_DONEP = 7'h14, C_DONEL = 7'h15;
  localparam logic [6:0] C_CYCLE = 7'h16, C_ALEAD = 7'h18, C_ALAG = 7'h19;
  localparam logic [6:0] C_MON_BASE = 7'h1a; // 26..34, three per variable
  localparam logic [6:0] C_POS = 7'h23, C_BRK_BASE = 7'h24;
  localparam logic [6:0] C_CT_BASE = 7'h28; // 40..49
  localparam logic [6:0] C_DI_BASE = 7'h37; // 55..62
  localparam logic [6:0] C_FREQ = 7'h3f;
  // pulse timing
  localparam int CLK_HZ      = 40_000_000;
  localparam int PULSE_MS    = 500;               // 0.5 s
  localparam int PULSE_CYC   = CLK_HZ / 1000 * PULSE_MS;
endpackage
`default_nettype wire

// ---- otfs_sel.sv ----
// output terminal function selector with apb code registers
`default_nettype none
module otfs_sel
#(
  parameter int N_OUT     = 4,                     // terminals
  parameter int FREQ_IDX  = 2,                     // third terminal
  parameter int MAG_W     = 16,                    // monitored value width
  parameter int PULSE_CYC = otfs_pkg::PULSE_CYC    // 0.5 s in cycles
)
(
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_reset_n,
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [11:0]            i_paddr,
  input  wire logic [31:0]            i_pwdata,
  output logic      [31:0]            o_prdata,
  output logic                        o_pready,
  output logic                        o_pslverr,
  input  wire logic                   i_volt_ok,
  input  wire logic                   i_estop,
  input  wire logic                   i_fault,
  input  wire logic                   i_alarm,
  input  wire logic                   i_run_cmd,
  input  wire logic                   i_running,
  input  wire logic                   i_speed_zero,
  input  wire logic                   i_accel,
  input  wire logic                   i_decel,
  input  wire logic                   i_stage_done,
  input  wire logic                   i_seq_done,
  input  wire logic                   i_seq_clear,
  input  wire logic                   i_cycle_done,
  input  wire logic                   i_a_leads,
  input  wire logic                   i_a_lags,
  input  wire logic [3*MAG_W-1:0]     i_mon_val,
  input  wire logic [3*MAG_W-1:0]     i_mon_lo,
  input  wire logic [3*MAG_W-1:0]     i_mon_hi,
  input  wire logic                   i_pos_reached,
  input  wire logic [2:0]             i_wire_break,
  input  wire logic [9:0]             i_ctr_tmr,
  input  wire logic [7:0]             i_din,
  input  wire logic                   i_freq_wave,
  output logic      [N_OUT-1:0]       o_term
);
  import otfs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait, unmapped reads zero with slverr
  logic [N_OUT*7-1:0] code_q;     // per terminal function code
  logic [N_OUT-1:0]   bus_q;      // fieldbus written states
  logic [N_OUT-1:0]   mod_q;      // module written states
  logic [5:0]         hyst_q;     // low/high latches per variable
  wire  wr_en   = i_psel && i_penable && i_pwrite;
  wire  sel_hit = i_paddr == OTFS_SEL_OFS;
  wire  bus_hit = i_paddr == OTFS_BUS_OFS;
  wire  mod_hit = i_paddr == OTFS_MOD_OFS;
  wire  sta_hit = i_paddr == OTFS_STAT_OFS;
  wire  str_hit = i_paddr == OTFS_STR_OFS;
  wire  any_hit = sel_hit || bus_hit || mod_hit || sta_hit || str_hit;
  wire  [31:0] sel_word;          // packed code view
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !any_hit;

  // read mux as if/else chain
  always_comb
  begin
    o_prdata = 32'h0;
    if (sel_hit)
      o_prdata = sel_word;
    else if (bus_hit)
      o_prdata[N_OUT-1:0] = bus_q;
    else if (mod_hit)
      o_prdata[N_OUT-1:0] = mod_q;
    else if (sta_hit)
      o_prdata[N_OUT-1:0] = o_term;
    else if (str_hit)
      o_prdata[5:0] = hyst_q;
  end

  // fieldbus and module write their own words
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      bus_q <= '0;
      mod_q <= '0;
    end
    else if (wr_en && bus_hit)
      bus_q <= i_pwdata[N_OUT-1:0];
    else if (wr_en && mod_hit)
      mod_q <= i_pwdata[N_OUT-1:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // pulse stretchers: 0.5 s after each completion event
  localparam int PW = $clog2(PULSE_CYC + 1);
  logic [PW-1:0] pcnt_q [3];      // stage, sequence, cycle
  logic [2:0]    pev;             // triggering events
  logic [2:0]    pon;             // pulses active
  logic          done_lvl_q;      // continuous completion level
  assign pev = {i_cycle_done, i_seq_done, i_stage_done};

  ////////////////////////////////////////////////////////////////////////
  // magnitude windows with hysteresis
  logic [2:0] in_win;             // inside window
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_pulse
      assign pon[g] = pcnt_q[g] != '0;
      // each new event restarts the full width
      always_ff @(posedge i_clk_sys or negedge i_reset_n)
      begin
        if (!i_reset_n)
          pcnt_q[g] <= '0;
        else if (pev[g])
          pcnt_q[g] <= PW'(PULSE_CYC);
        else if (pon[g])
          pcnt_q[g] <= pcnt_q[g] - 1'b1;
      end
    end
    for (g = 0; g < 3; g++)
    begin : g_mon
      // sign ignored: values compare as unsigned magnitudes
      wire [MAG_W-1:0] v  = i_mon_val[g*MAG_W +: MAG_W];
      wire [MAG_W-1:0] lo = i_mon_lo[g*MAG_W +: MAG_W];
      wire [MAG_W-1:0] hi = i_mon_hi[g*MAG_W +: MAG_W];
      assign in_win[g] = (v >= lo) && (v <= hi);
      // low latch set below lower, cleared above upper
      always_ff @(posedge i_clk_sys or negedge i_reset_n)
      begin
        if (!i_reset_n)
          hyst_q[2*g+1:2*g] <= 2'b00;
        else
        begin
          if (v < lo)
            hyst_q[2*g] <= 1'b1;
          else if (v > hi)
            hyst_q[2*g] <= 1'b0;
          if (v > hi)
            hyst_q[2*g+1] <= 1'b1;
          else if (v < lo)
            hyst_q[2*g+1] <= 1'b0;
        end
      end
    end
  endgenerate

  // completion level holds until the sequence restarts
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
      done_lvl_q <= 1'b0;
    else if (i_seq_done)
      done_lvl_q <= 1'b1;
    else if (i_seq_clear)
      done_lvl_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // per terminal code register and source selection
  logic [N_OUT-1:0] term_d;       // selected level
  generate
    for (g = 0; g < N_OUT; g++)
    begin : g_term
      wire [6:0] c = code_q[g*7 +: 7];
      wire [6:0] mo = c - C_MON_BASE;
      wire [6:0] ct = c - C_CT_BASE;
      wire [6:0] di = c - C_DI_BASE;
      wire [6:0] br = c - C_BRK_BASE;
      wire is_mon = c >= C_MON_BASE && c < C_MON_BASE + 7'd9;
      wire [1:0] mv = mo < 7'd3 ? 2'd0 : (mo < 7'd6 ? 2'd1 : 2'd2);
      wire [1:0] mk = 2'(mo - 7'(mv) * 7'd3);
      wire mon_o = mk == 2'd0 ? hyst_q[2*mv] :
                   (mk == 2'd1 ? hyst_q[2*mv+1] : in_win[mv]);
      // code write from the packed word
      assign sel_word[g*OTFS_CODE_STRIDE +: OTFS_CODE_STRIDE] = {1'b0, c};
      always_ff @(posedge i_clk_sys or negedge i_reset_n)
      begin
        if (!i_reset_n)
          code_q[g*7 +: 7] <= OTFS_CODE_RST;
        else if (wr_en && sel_hit)
          code_q[g*7 +: 7] <= i_pwdata[g*OTFS_CODE_STRIDE +: 7];
      end
      // source mux: anything unlisted is inactive
      always_comb
      begin
        term_d[g] = 1'b0;
        if (c == C_READY)
          term_d[g] = i_volt_ok && !i_estop;
        else if (c == C_FAULT)
          term_d[g] = i_fault;
        else if (c == C_ALARM)
          term_d[g] = i_alarm;
        else if (c == C_FLTALM)
          term_d[g] = i_fault || i_alarm;
        else if (c == C_RUNCMD)
          term_d[g] = i_run_cmd;
        else if (c == C_ZERO)
          term_d[g] = i_running && i_speed_zero;
        else if (c == C_NZERO)
          term_d[g] = !i_speed_zero;
        else if (c == C_ACC)
          term_d[g] = i_accel;
        else if (c == C_DEC)
          term_d[g] = i_decel;
        else if (c == C_BUS)
          term_d[g] = bus_q[g];
        else if (c == C_MOD)
          term_d[g] = mod_q[g];
        else if (c == C_STAGE)
          term_d[g] = pon[0];
        else if (c == C_DONEP)
          term_d[g] = pon[1];
        else if (c == C_DONEL)
          term_d[g] = done_lvl_q;
        else if (c == C_CYCLE)
          term_d[g] = pon[2];
        else if (c == C_ALEAD)
          term_d[g] = i_a_leads;
        else if (c == C_ALAG)
          term_d[g] = i_a_lags;
        else if (is_mon)
          term_d[g] = mon_o;
        else if (c == C_POS)
          term_d[g] = i_pos_reached;
        else if (br < 7'd3)
          term_d[g] = i_wire_break[br[1:0]];
        else if (ct < 7'd10)
          term_d[g] = i_ctr_tmr[ct[3:0]];
        else if (di < 7'd8)
          term_d[g] = i_din[di[2:0]];
        else if (c == C_FREQ && g == FREQ_IDX)
          term_d[g] = i_freq_wave;
      end
    end
    for (g = N_OUT; g < 4; g++)
    begin : g_pad
      assign sel_word[g*8 +: 8] = 8'h00;
    end
  endgenerate

  // terminals registered
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_term <= '0;
    else
      o_term <= term_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  // terminal zero is watched for routing, and the third terminal for the
  // frequency code: lanes share one mux body except its frequency branch
  wire [6:0]       chk_code0 = code_q[6:0];          // terminal zero code
  wire [MAG_W-1:0] chk_v0    = i_mon_val[MAG_W-1:0]; // variable zero
  wire [MAG_W-1:0] chk_lo0   = i_mon_lo[MAG_W-1:0];  // its lower limit
  wire [MAG_W-1:0] chk_hi0   = i_mon_hi[MAG_W-1:0];  // its upper limit

  // steady fault code passes the trip flag one cycle on
  a_fault_route: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n)
    chk_code0 == C_FAULT && $stable(chk_code0)
    |=> o_term[0] == $past(i_fault))
    else $error("fault route");
  // ready needs good supply and no stop request
  a_ready_route: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n)
    chk_code0 == C_READY && $stable(chk_code0)
    |=> o_term[0] == $past(i_volt_ok && !i_estop))
    else $error("ready route");
  // run command level follows the command, not the motion
  a_runcmd_route: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n)
    chk_code0 == C_RUNCMD && $stable(chk_code0)
    |=> o_term[0] == $past(i_run_cmd))
    else $error("run command route");
  // nonzero speed code is the inverse of the zero flag
  a_speed_route: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n)
    chk_code0 == C_NZERO && $stable(chk_code0)
    |=> o_term[0] == $past(!i_speed_zero))
    else $error("speed route");
  // a reserved code keeps the terminal off
  a_undef_idle: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n)
    chk_code0 == 7'h27 && $stable(chk_code0)
    |=> !o_term[0])
    else $error("reserved code drives");
  // a stage event keeps its pulse up for at least eight cycles
  a_pulse_start: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n)
    i_stage_done
    |=> pon[0] [*8])
    else $error("stage pulse short");
  // a cycle event reloads the full pulse width
  a_pulse_load: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n)
    i_cycle_done
    |=> pcnt_q[2] == PW'(PULSE_CYC))
    else $error("cycle pulse width");
  // completion level only drops on an explicit clear
  a_level_hold: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n)
    done_lvl_q && !i_seq_clear
    |=> done_lvl_q)
    else $error("completion level dropped");
  // falling below the lower limit sets the low latch
  a_low_set: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n)
    chk_v0 < chk_lo0
    |=> hyst_q[0])
    else $error("low latch not set");
  // low latch survives until the upper limit is passed
  a_low_hold: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n)
    hyst_q[0] && !(chk_v0 > chk_hi0)
    |=> hyst_q[0])
    else $error("low latch dropped");
  // passing the upper limit sets the high latch
  a_high_set: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n)
    chk_v0 > chk_hi0
    |=> hyst_q[1])
    else $error("high latch not set");
  // window code is high only with the limits included
  a_win_route: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n)
    chk_code0 == C_MON_BASE + 7'd2 && $stable(chk_code0)
    |=> o_term[0] == $past(chk_v0 >= chk_lo0 && chk_v0 <= chk_hi0))
    else $error("window route");
  // first analog wire break reaches the terminal
  a_break_route: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n)
    chk_code0 == C_BRK_BASE && $stable(chk_code0)
    |=> o_term[0] == $past(i_wire_break[0]))
    else $error("wire break route");
  // first counter output reaches the terminal
  a_ctr_route: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n)
    chk_code0 == C_CT_BASE && $stable(chk_code0)
    |=> o_term[0] == $past(i_ctr_tmr[0]))
    else $error("counter route");
  // first digital input is mirrored
  a_din_route: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n)
    chk_code0 == C_DI_BASE && $stable(chk_code0)
    |=> o_term[0] == $past(i_din[0]))
    else $error("input mirror route");
  // frequency code is refused away from the third terminal
  a_freq_only3: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n)
    chk_code0 == C_FREQ && $stable(chk_code0)
    |=> !o_term[0])
    else $error("freq on wrong pin");
  // frequency code on the third terminal passes the wave
  a_freq_route: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n)
    code_q[FREQ_IDX*7 +: 7] == C_FREQ && $stable(code_q[FREQ_IDX*7 +: 7])
    |=> o_term[FREQ_IDX] == $past(i_freq_wave))
    else $error("freq route");
  // fieldbus word lands on the access edge
  a_bus_write: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n)
    wr_en && bus_hit
    |=> bus_q == $past(i_pwdata[N_OUT-1:0]))
    else $error("bus write lost");
  // module word lands on the access edge
  a_mod_write: assert property (@(posedge i_clk_sys)
    disable iff (!i_reset_n)
    wr_en && mod_hit
    |=> mod_q == $past(i_pwdata[N_OUT-1:0]))
    else $error("module write lost");
  // main scenarios worth seeing at least once
  c_fault: cover property (@(posedge i_clk_sys) o_term[0] && i_fault);
  c_pulse: cover property (@(posedge i_clk_sys) pon[1]);
  c_win: cover property (@(posedge i_clk_sys) in_win[0] && hyst_q[0]);
  c_freq: cover property (@(posedge i_clk_sys) o_term[FREQ_IDX] &&
    code_q[FREQ_IDX*7 +: 7] == C_FREQ);
  c_level: cover property (@(posedge i_clk_sys) done_lvl_q && o_term[0]);
endmodule
`default_nettype wire

// ---- otfs_field.sv ----
// field load model: a relay coil that times each on period of a terminal
`default_nettype none
module otfs_field
(
  input  wire logic i_clk_sys,
  input  wire logic i_line,
  output var  int   o_width
);
  timeunit 1ns;
  timeprecision 100ps;
  int run = 0; // cycles the coil has been on
  initial o_width = 0;
  // width is latched on the falling side so a stuck line never reports
  always @(posedge i_clk_sys)
  begin
    if (i_line === 1'b1)
      run <= run + 1;
    else
    begin
      if (run != 0)
        o_width <= run;
      run <= 0;
    end
  end
endmodule
`default_nettype wire

// ---- output_terminal_function_select_tb.sv ----
// self-checking bench for the output terminal function selector
`default_nettype none
`define CHK(a, b) \
  begin n_tests++; if ((a) !== (b)) begin mismatches++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module output_terminal_function_select_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import otfs_pkg::*;
  localparam int PW = 20; // short pulse so the run stays brief
  logic clk = 0, rn = 0, psel = 0, pen = 0, pwr = 0;
  logic [11:0] pa = '0;
  logic [31:0] pwd = '0, rd;
  logic volt_ok = 0, estop = 0, fault = 0, alarm = 0, runc = 0, running = 0;
  logic spd0 = 0, acc = 0, dec = 0, stg = 0, seqd = 0, seqc = 0, cyc = 0;
  logic alead = 0, alag = 0, pos = 0, fw = 0, err;
  logic [2:0] wb = '0;
  logic [9:0] ct = '0;
  logic [7:0] din = '0;
  logic [47:0] mv = '0, ml = {3{16'h0064}}, mh = {3{16'h00c8}};
  wire logic [31:0] prd;
  wire logic pready, perr;
  wire logic [3:0] term;
  int mismatches = 0, n_tests = 0, cyc_n = 0, width;
  otfs_sel #(.PULSE_CYC(PW)) otfs_sel_i (.i_clk_sys(clk), .i_reset_n(rn),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
    .i_pwdata(pwd), .o_prdata(prd), .o_pready(pready), .o_pslverr(perr),
    .i_volt_ok(volt_ok), .i_estop(estop), .i_fault(fault), .i_alarm(alarm),
    .i_run_cmd(runc), .i_running(running), .i_speed_zero(spd0),
    .i_accel(acc), .i_decel(dec), .i_stage_done(stg), .i_seq_done(seqd),
    .i_seq_clear(seqc), .i_cycle_done(cyc), .i_a_leads(alead),
    .i_a_lags(alag), .i_mon_val(mv), .i_mon_lo(ml), .i_mon_hi(mh),
    .i_pos_reached(pos), .i_wire_break(wb), .i_ctr_tmr(ct), .i_din(din),
    .i_freq_wave(fw), .o_term(term));
  otfs_field otfs_field_i (.i_clk_sys(clk), .i_line(term[0]), .o_width(width));
  initial forever #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  // one apb transfer; data and response taken at the ready edge
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    // no wait count assumed: only the hang guard ends a stuck wait
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prd;
    err = perr;
    psel <= 0;
    pen <= 0;
    // idle edge so a following call never re-raises psel at once
    @(posedge clk);
  endtask
  // same code on every terminal, then look at terminal zero
  task automatic tc(input logic [6:0] c, input logic e);
    bus(1, OTFS_SEL_OFS, {4{1'b0, c}});
    repeat (3) @(posedge clk);
    `CHK(term[0], e)
  endtask
  // move one monitored value, then check a code
  task automatic mt(int k, logic [15:0] v, logic [6:0] c, logic e);
    mv[16*k +: 16] <= v;
    tc(c, e);
  endtask
  // event pulse k: 0 stage, 1 sequence, 2 cycle
  task automatic pls(logic [6:0] c, int k);
    tc(c, 0);
    if (k == 0) stg <= 1; else if (k == 1) seqd <= 1; else cyc <= 1;
    @(posedge clk);
    {stg, seqd, cyc} <= '0;
    repeat (2) @(posedge clk);
    `CHK(term[0], 1'b1)
    repeat (PW + 4) @(posedge clk);
    `CHK(width, PW)
    `CHK(term[0], 1'b0)
  endtask
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cyc_n++;
    if (cyc_n == 20000)
    begin
      mismatches++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge clk);
    rn <= 1;
    @(posedge clk);
    bus(0, OTFS_SEL_OFS, '0);
    `CHK(rd, 32'h0)
    bus(0, 12'h020, '0);
    `CHK({err, rd}, 33'h1_0000_0000)
    tc(C_READY, 0);
    volt_ok <= 1;
    tc(C_READY, 1);
    estop <= 1;
    tc(C_READY, 0);
    fault <= 1;
    tc(C_FAULT, 1);
    tc(C_ALARM, 0);
    tc(C_FLTALM, 1);
    tc(C_RUNCMD, 0);
    runc <= 1;
    tc(C_RUNCMD, 1);
    running <= 1; spd0 <= 1;
    tc(C_ZERO, 1);
    running <= 0;
    tc(C_ZERO, 0);
    tc(C_NZERO, 0);
    acc <= 1;
    tc(C_ACC, 1);
    tc(C_DEC, 0);
    bus(1, OTFS_BUS_OFS, 32'h1);
    tc(C_BUS, 1);
    bus(1, OTFS_MOD_OFS, 32'h2);
    tc(C_MOD, 0);
    `CHK(term, 4'h2)
    bus(0, OTFS_STAT_OFS, '0);
    `CHK(rd[3:0], 4'h2)
    alead <= 1;
    tc(C_ALEAD, 1);
    tc(C_ALAG, 0);
    tc(C_POS, 0);
    pos <= 1;
    tc(C_POS, 1);
    for (int k = 0; k < 3; k++)
    begin
      mt(k, 16'd250, C_MON_BASE + 7'(3*k), 0);
      mt(k, 16'd50, C_MON_BASE + 7'(3*k), 1);
      mt(k, 16'd150, C_MON_BASE + 7'(3*k), 1);
      mt(k, 16'd250, C_MON_BASE + 7'(3*k), 0);
      mt(k, 16'd150, C_MON_BASE + 7'(3*k+1), 1);
      mt(k, 16'd50, C_MON_BASE + 7'(3*k+1), 0);
      mt(k, 16'd100, C_MON_BASE + 7'(3*k+2), 1);
      mt(k, 16'd201, C_MON_BASE + 7'(3*k+2), 0);
      wb <= 3'(1 << k);
      tc(C_BRK_BASE + 7'(k), 1);
      tc(C_BRK_BASE + 7'((k + 1) % 3), 0);
    end
    // every variable ended above its window: high latches only
    bus(0, OTFS_STR_OFS, '0);
    `CHK(rd, 32'h2a)
    for (int n = 0; n < 10; n++)
    begin
      ct <= 10'(1 << n);
      tc(C_CT_BASE + 7'(n), 1);
      tc(C_CT_BASE + 7'((n + 1) % 10), 0);
    end
    for (int n = 0; n < 8; n++)
    begin
      din <= 8'(1 << n);
      tc(C_DI_BASE + 7'(n), 1);
      tc(C_DI_BASE + 7'((n + 1) % 8), 0);
    end
    pls(C_STAGE, 0);
    pls(C_DONEP, 1);
    pls(C_CYCLE, 2);
    seqc <= 1;
    tc(C_DONEL, 0);
    seqc <= 0;
    seqd <= 1;
    @(posedge clk);
    seqd <= 0;
    tc(C_DONEL, 1);
    repeat (PW + 5) @(posedge clk);
    `CHK(term[0], 1'b1)
    seqc <= 1;
    tc(C_DONEL, 0);
    seqc <= 0;
    {volt_ok, estop, fault, alarm, spd0, dec, alag, fw} <= '1;
    {ct, din, wb} <= '1;
    tc(7'h00, 0);
    tc(7'h27, 0);
    tc(7'h32, 0);
    tc(7'h36, 0);
    tc(7'h40, 0);
    tc(7'h47, 0);
    tc(7'h7f, 0);
    tc(C_FREQ, 0);
    `CHK(term, 4'h4)
    bus(0, OTFS_SEL_OFS, '0);
    `CHK(rd, 32'h3f3f3f3f)
    close_out();
  end
endmodule
`default_nettype wire
